// file: rtl/mss_regs.vh
// Constants of the motor start sequencer: codes, ranges, defaults, timing.
// Assumes inclusion by bare name from the sequencer sources.
`ifndef MSS_REGS_VH
`define MSS_REGS_VH
// Start method codes
`define MSS_METHOD_DIRECT     2'h0
`define MSS_METHOD_TRACK      2'h1
`define MSS_METHOD_PREEXC     2'h2
// Tracking origin codes
`define MSS_ORIGIN_STOP       2'h0
`define MSS_ORIGIN_ZERO       2'h1
`define MSS_ORIGIN_MAX        2'h2
// Tracking rate range and default
`define MSS_RATE_MIN          7'h01
`define MSS_RATE_MAX          7'h64
`define MSS_RATE_DEFAULT      7'h14
// Frequency in 0.01 Hz; launch frequency at most 10.00 Hz
`define MSS_LAUNCH_FREQ_MAX   16'h03e8
// Durations in 0.1 s; at most 100.0 s
`define MSS_DUR_MAX           10'h3e8
// Current base cap in percent of drive rating
`define MSS_BASE_CAP_PCT      8'h50
// Tick period in ms and clock rate in kHz
`define MSS_TICK_MS           100
`define MSS_CLK_KHZ           25000
`define MSS_TICK_CYCLES       (`MSS_TICK_MS * `MSS_CLK_KHZ)
`endif

// file: rtl/mss_tick_div.v
// Divider producing the 0.1 s enable pulse from core_clk.
// Assumes a synchronous active-high reset; clear restarts the period.
`timescale 1ns/1ps
`include "mss_regs.vh"
module mss_tick_div #(
  parameter TICK_CYCLES = `MSS_TICK_CYCLES
) (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Control
  input  wire clear,
  // Output pulse
  output reg  tick
);
  // ************************************************
  // Cycle counter
  // ************************************************
  reg [31:0] cnt_reg;   // Cycles elapsed in the period
  // Count up, pulse at the end of each period
  always @(posedge core_clk) begin
    if (rst || clear) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
    end else if (cnt_reg >= TICK_CYCLES - 1) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end
endmodule // mss_tick_div

// file: rtl/mss_motor_start_sequencer.v
// Start sequencer of a motor drive: method choice, braking, pre-excitation,
// speed tracking and launch-frequency hold. Assumes settings from the drive's
// control logic on the same clock, and a power-stage controller outside.
`timescale 1ns/1ps
`include "mss_regs.vh"
module mss_motor_start_sequencer #(
  parameter TICK_CYCLES = `MSS_TICK_CYCLES
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Commands
  input  wire        start_cmd,
  input  wire        stop_cmd,
  input  wire        reverse_cmd,
  // Settings
  input  wire [1:0]  start_method_select,
  input  wire [1:0]  tracking_origin_select,
  input  wire [6:0]  tracking_rate,
  input  wire [15:0] launch_frequency,
  input  wire [9:0]  launch_hold_duration,
  input  wire [6:0]  prebrake_current_pct,
  input  wire [9:0]  prebrake_duration,
  input  wire        motor_is_async,
  input  wire [15:0] target_frequency,
  input  wire [15:0] max_frequency,
  input  wire [15:0] stop_frequency,
  input  wire [15:0] motor_rated_current,
  input  wire [15:0] drive_rated_current,
  // Tracking feedback
  input  wire [15:0] measured_frequency,
  input  wire        measured_reverse,
  input  wire        track_locked,
  // Outputs to power stage
  output reg  [15:0] output_frequency,
  output reg         output_reverse,
  output reg         dc_brake_active,
  output reg         preexcite_active,
  output reg  [15:0] inject_current,
  output reg         tracking_active,
  output reg  [15:0] track_search_freq,
  output reg  [6:0]  track_step,
  output reg         launch_hold_active,
  output reg         accel_enable,
  output reg         seq_time_tick,
  output reg         standby,
  output reg         running
);
  // ************************************************
  // States
  // ************************************************
  localparam ST_IDLE    = 3'h0;  // Stopped
  localparam ST_BRAKE   = 3'h1;  // Start DC braking
  localparam ST_PREEXC  = 3'h2;  // Pre-excitation
  localparam ST_TRACK   = 3'h3;  // Speed tracking search
  localparam ST_HOLD    = 3'h4;  // Launch frequency hold
  localparam ST_RUN     = 3'h5;  // Handed to ramp logic
  localparam ST_STANDBY = 3'h6;  // Target below launch
  // Phase timing: the divider restarts on every start and on every entry to
  // hold, so the first tick of a phase comes one period after entry,
  // and a phase of N ticks lasts N periods plus one cycle.
  // A zero braking or pre-excitation time never enters its phase; a zero
  // hold costs a single cycle in hold before the run.

  reg [2:0]  state_reg;          // Current state
  reg [2:0]  state_next;         // Next state
  reg [9:0]  dur_cnt_reg;        // Elapsed ticks of the phase
  reg        tick_clear;         // Restart tick divider
  wire       tick;               // 0.1 s pulse
  reg        was_reverse_reg;    // Direction of last run
  reg [15:0] base_current;       // Injection base value
  reg [31:0] base_cap_prod;      // Drive current times cap
  reg [15:0] base_cap;           // Capped drive current
  reg [31:0] base_cap_quot;      // Full-width quotient of the cap
  reg [31:0] inject_prod;        // Base times percentage
  reg [6:0]  rate_eff;           // Rate clamped to range
  reg [15:0] search_start;       // Search origin frequency

  // ************************************************
  // Tick divider
  // ************************************************
  // One shared divider; clearing it on phase entry makes every phase time
  // start from a full period instead of a random part of one
  mss_tick_div #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (tick_clear),
    .tick     (tick)
  );

  // ************************************************
  // Derived settings
  // ************************************************
  // Base current, percentage scaling and tracking rate
  always @* begin
    base_cap_prod = drive_rated_current * {8'h0, `MSS_BASE_CAP_PCT};
    // Divide at full width, then keep the low half: the cap is at most
    // eighty percent of a 16-bit rating, so the slice drops nothing
    base_cap_quot = base_cap_prod / 32'd100;
    base_cap      = base_cap_quot[15:0];
    base_current  = (motor_rated_current <= base_cap) ? motor_rated_current : base_cap;
    inject_prod   = (base_current * {9'h0, prebrake_current_pct}) / 32'd100;
    // Out-of-range rates are clamped rather than refused so the search
    // always moves; the step is only a hint to the tracking loop outside
    // rate range clamp
    if (tracking_rate < `MSS_RATE_MIN)
      rate_eff = `MSS_RATE_MIN;
    else if (tracking_rate > `MSS_RATE_MAX)
      rate_eff = `MSS_RATE_MAX;
    else
      rate_eff = tracking_rate;
    // Code 3 is unused and falls back to the stop frequency
    // search origin choice
    case (tracking_origin_select)
      `MSS_ORIGIN_STOP: search_start = stop_frequency;
      `MSS_ORIGIN_ZERO: search_start = 16'h0;
      `MSS_ORIGIN_MAX:  search_start = max_frequency;
      default:          search_start = stop_frequency;
    endcase
  end

  // ************************************************
  // Sequence control
  // ************************************************
  // A start is only looked at in idle, so a start held high through a
  // stop starts again as soon as the stop is released. The ramp beyond
  // launch lives outside: this block hands over the frequency it reached
  // and raises accel_enable, nothing more. Direction changes during the
  // run are the ramp logic's business, not this sequencer's.
  // Next state; the launch phase decided after any pre-phase
  always @* begin
    state_next = state_reg;
    tick_clear = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Stop wins over a start in the same cycle
        if (start_cmd && !stop_cmd) begin
          tick_clear = 1'b1;
          case (start_method_select)
            `MSS_METHOD_DIRECT: begin
              if (prebrake_duration != 10'h0)
                state_next = ST_BRAKE;
              else
                state_next = ST_HOLD;
            end
            `MSS_METHOD_TRACK: state_next = ST_TRACK;
            `MSS_METHOD_PREEXC: begin
              if (motor_is_async && prebrake_duration != 10'h0)
                state_next = ST_PREEXC;
              else
                state_next = ST_HOLD;
            end
            default: state_next = ST_HOLD;
          endcase
        end
      end
      ST_BRAKE, ST_PREEXC: begin
        if (tick && dur_cnt_reg + 10'h1 >= prebrake_duration) begin
          state_next = ST_HOLD;
          tick_clear = 1'b1;
        end
      end
      ST_TRACK: begin
        // Locked search goes straight to ramping from the tracked point
        if (track_locked)
          state_next = ST_RUN;
      end
      ST_HOLD: begin
        // Target watched every cycle, also while the hold runs
        // target below launch
        if (target_frequency < launch_frequency)
          state_next = ST_STANDBY;
        else if (launch_hold_duration == 10'h0 || reverse_cmd != was_reverse_reg)
          state_next = ST_RUN;
        else if (tick && dur_cnt_reg + 10'h1 >= launch_hold_duration)
          state_next = ST_RUN;
      end
      ST_STANDBY: begin
        // Starts once the target climbs to the launch frequency
        if (target_frequency >= launch_frequency) begin
          state_next = ST_HOLD;
          tick_clear = 1'b1;
        end
      end
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_IDLE;
    endcase
    // Catches every entry to hold so no launch frequency leaks for a cycle
    // no launch above target
    if (state_next == ST_HOLD && target_frequency < launch_frequency)
      state_next = ST_STANDBY;
    if (stop_cmd)
      state_next = ST_IDLE;
  end

  // State, phase counter and outputs
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg          <= ST_IDLE;
      dur_cnt_reg        <= 10'h0;
      was_reverse_reg    <= 1'b0;
      output_frequency   <= 16'h0;
      output_reverse     <= 1'b0;
      dc_brake_active    <= 1'b0;
      preexcite_active   <= 1'b0;
      inject_current     <= 16'h0;
      tracking_active    <= 1'b0;
      track_search_freq  <= 16'h0;
      track_step         <= `MSS_RATE_DEFAULT;
      launch_hold_active <= 1'b0;
      accel_enable       <= 1'b0;
      seq_time_tick      <= 1'b0;
      standby            <= 1'b0;
      running            <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Phase count restarts on every state change
      // and saturates, so a long phase cannot wrap and end early
      if (state_next != state_reg || tick_clear)
        dur_cnt_reg <= 10'h0;
      else if (tick && dur_cnt_reg != `MSS_DUR_MAX)
        dur_cnt_reg <= dur_cnt_reg + 10'h1;
      dc_brake_active    <= (state_next == ST_BRAKE);
      preexcite_active   <= (state_next == ST_PREEXC);
      inject_current     <= (state_next == ST_BRAKE || state_next == ST_PREEXC) ?
                            inject_prod[15:0] : 16'h0;
      tracking_active    <= (state_next == ST_TRACK);
      track_step         <= rate_eff;
      launch_hold_active <= (state_next == ST_HOLD);
      accel_enable       <= (state_next == ST_RUN);
      // Pulse follows the tick by one cycle; phase judged before the edge
      // hold and run in sequence time
      seq_time_tick      <= tick && (state_reg == ST_HOLD || state_reg == ST_RUN);
      standby            <= (state_next == ST_STANDBY);
      running            <= (state_next == ST_HOLD || state_next == ST_RUN ||
                             state_next == ST_TRACK);
      // Direction remembered for the next start's reversal check
      // Only a finished run counts; an aborted launch keeps the old direction
      if (state_reg == ST_RUN && state_next == ST_IDLE)
        was_reverse_reg <= output_reverse;
      // Frequency and direction per phase; brake and pre-excite keep the
      // last direction so the reversal check still sees the previous run
      case (state_next)
        ST_TRACK: begin
          if (state_reg != ST_TRACK) begin
            track_search_freq <= search_start;
            output_frequency  <= search_start;
          end else begin
            track_search_freq <= measured_frequency;
            output_frequency  <= measured_frequency;
          end
          output_reverse <= measured_reverse;
        end
        ST_HOLD: begin
          output_frequency <= (launch_frequency > `MSS_LAUNCH_FREQ_MAX) ?
                              `MSS_LAUNCH_FREQ_MAX : launch_frequency;
          output_reverse   <= reverse_cmd;
        end
        ST_RUN: begin
          // Ramp logic outside takes over from the current value
          if (state_reg == ST_TRACK)
            output_frequency <= measured_frequency;
        end
        default: begin
          output_frequency <= 16'h0;
        end
      endcase
    end
  end
endmodule // mss_motor_start_sequencer

// file: tb/mss_start_seq_sva.sv
// Checker of the start sequencer, watching only its top ports.
// Assumes TICK_CYCLES of at least 8 and a sync active-high reset.
`timescale 1ns/1ps
module mss_start_seq_sva #(
  parameter TICK_CYCLES = 10
) (
  input wire        core_clk,
  input wire        rst,
  input wire        start_cmd,
  input wire        stop_cmd,
  input wire        motor_is_async,
  input wire [15:0] launch_frequency,
  input wire [15:0] output_frequency,
  input wire [15:0] inject_current,
  input wire [15:0] track_search_freq,
  input wire        dc_brake_active,
  input wire        preexcite_active,
  input wire        tracking_active,
  input wire        launch_hold_active,
  input wire        accel_enable,
  input wire        seq_time_tick,
  input wire        standby
);
  // No phase flag up means the sequencer idles
  wire idle = !(dc_brake_active | preexcite_active | tracking_active |
                launch_hold_active | accel_enable | standby);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_START_TAKEN: assert property (start_cmd && !stop_cmd && idle |=> !idle)
    else $error("start not taken");
  AST_STOP_ABORT: assert property (stop_cmd |=> idle && output_frequency == 16'h0000)
    else $error("stop did not abort");
  AST_STANDBY_ZERO: assert property (standby |-> output_frequency == 16'h0000)
    else $error("standby with output");
  AST_PREEXC_ASYNC: assert property (preexcite_active |-> motor_is_async)
    else $error("pre-excite on synchronous motor");
  AST_NO_INJECT: assert property (!(dc_brake_active || preexcite_active) |->
    inject_current == 16'h0000) else $error("current outside brake");
  AST_HOLD_FREQ: assert property (launch_hold_active |-> output_frequency ==
    (launch_frequency > 16'h03e8 ? 16'h03e8 : launch_frequency)) else $error("hold freq");
  AST_ACCEL_EXCL: assert property (accel_enable |-> !launch_hold_active &&
    !dc_brake_active && !preexcite_active) else $error("accel during start phase");
  AST_TICK_PULSE: assert property (seq_time_tick |=> !seq_time_tick)
    else $error("tick longer than one cycle");
  AST_BRAKE_MIN: assert property (disable iff (rst || stop_cmd)
    $rose(dc_brake_active) |-> dc_brake_active[*8]) else $error("brake shorter than a tick");
  AST_SEQ_TICK_PHASE: assert property (seq_time_tick |->
    $past(launch_hold_active || accel_enable)) else $error("sequence tick outside hold or run");
  AST_TRACK_FOLLOW: assert property (tracking_active |->
    track_search_freq == output_frequency) else $error("search frequency differs from output");
endmodule // mss_start_seq_sva
bind mss_motor_start_sequencer mss_start_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_i (
  .core_clk, .rst, .start_cmd, .stop_cmd, .motor_is_async, .launch_frequency,
  .output_frequency, .inject_current, .track_search_freq, .dc_brake_active, .preexcite_active,
  .tracking_active, .launch_hold_active, .accel_enable, .seq_time_tick, .standby);

// file: tb/mss_motor_model.sv
// Motor seen through the power stage: coasting speed and tracking lock.
// Assumes tracking_active from the sequencer on the same clock.
`timescale 1ns/1ps
module mss_motor_model #(
  parameter LOCK_CYC = 20
) (
  // Clock
  input  wire        core_clk,
  // Drive side
  input  wire        tracking_active,
  // Feedback
  output reg  [15:0] measured_frequency,
  output reg         measured_reverse,
  output reg         track_locked
);
  reg [7:0] cnt_reg = 8'h00; // Cycles spent tracking
  initial {measured_frequency, measured_reverse, track_locked} = 18'h0;
  always @(posedge core_clk) begin
    measured_frequency <= 16'h0400 + {8'h00, cnt_reg};
    measured_reverse   <= 1'b0;
    cnt_reg            <= tracking_active ? cnt_reg + 8'h01 : 8'h00;
    track_locked       <= tracking_active && (cnt_reg >= LOCK_CYC);
  end
endmodule // mss_motor_model

// file: tb/mss_motor_start_sequencer_tb.sv
// Testbench of the start sequencer: scenarios, scoreboard and verdict.
// Assumes the bound checker and the motor model on the far side.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((e) !== (a)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module mss_motor_start_sequencer_tb;
  reg         core_clk, rst, start_cmd, stop_cmd, reverse_cmd, motor_is_async, chk;
  reg  [1:0]  start_method_select, tracking_origin_select;
  reg  [6:0]  tracking_rate, prebrake_current_pct;
  reg  [9:0]  launch_hold_duration, prebrake_duration;
  reg  [15:0] launch_frequency, target_frequency, max_frequency, stop_frequency;
  reg  [15:0] motor_rated_current, drive_rated_current;
  wire [15:0] measured_frequency, output_frequency, inject_current, track_search_freq;
  wire [6:0]  track_step;
  wire        measured_reverse, track_locked, output_reverse, dc_brake_active;
  wire        preexcite_active, tracking_active, launch_hold_active, accel_enable;
  wire        seq_time_tick, standby, running;
  integer     seed, mismatches, tests_run, cyc;
  reg  [93:0] exp_q[$];  // Expected snapshot and its mask
  reg  [93:0] e;
  reg  [15:0] org;       // Expected tracking origin
  // Flags, output frequency, injected current, running, direction and step
  wire [46:0] snap = {dc_brake_active, preexcite_active, tracking_active,
                      launch_hold_active, accel_enable, standby, output_frequency, inject_current,
                      running, output_reverse, track_step};
  mss_motor_start_sequencer #(.TICK_CYCLES(10)) mss_motor_start_sequencer_i (
    .core_clk, .rst, .start_cmd, .stop_cmd, .reverse_cmd, .start_method_select,
    .tracking_origin_select, .tracking_rate, .launch_frequency, .launch_hold_duration,
    .prebrake_current_pct, .prebrake_duration, .motor_is_async, .target_frequency,
    .max_frequency, .stop_frequency, .motor_rated_current, .drive_rated_current,
    .measured_frequency, .measured_reverse, .track_locked, .output_frequency,
    .output_reverse, .dc_brake_active, .preexcite_active, .inject_current,
    .tracking_active, .track_search_freq, .track_step, .launch_hold_active,
    .accel_enable, .seq_time_tick, .standby, .running);
  mss_motor_model mss_motor_model_i (.core_clk, .tracking_active, .measured_frequency,
    .measured_reverse, .track_locked);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task stop_test;
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task w(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Note the expectation; the monitor compares at the next edge
  task ex(input [5:0] f, input [15:0] q, input [15:0] j, input [1:0] m);
    // Direction known in hold, run and tracking; tracking takes the model's
    exp_q.push_back({f, q, j, |f[3:1], ((start_method_select == 2'h1) ? 1'b0 : reverse_cmd),
                     tracking_rate, 6'h3f, {16{m[1]}}, {16{m[0]}}, 1'b1, |f[3:1], 7'h7f});
    chk = 1'b1;
    w(1);
    chk = 1'b0;
  endtask
  task go(input [1:0] m, input a, input [9:0] p, input [9:0] h, input r);
    {start_method_select, motor_is_async, prebrake_duration} = {m, a, p};
    {launch_hold_duration, reverse_cmd, start_cmd} = {h, r, 1'b1};
    w(1);
    start_cmd = 1'b0;
  endtask
  task halt;
    stop_cmd = 1'b1;
    w(1);
    stop_cmd = 1'b0;
    w(1);
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (chk) begin
      e = exp_q.pop_front();
      `CHK("snapshot", e[93:47] & e[46:0], snap & e[46:0])
    end
    if (cyc == 3000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    {seed, mismatches, tests_run, cyc, chk} = {32'd20, 32'd0, 32'd0, 32'd0, 1'b0};
    {rst, start_cmd, stop_cmd, reverse_cmd, motor_is_async} = 5'h10;
    {start_method_select, tracking_origin_select, tracking_rate} = {4'h0, 7'h14};
    {launch_hold_duration, prebrake_duration, prebrake_current_pct} = {20'h0, 7'h32};
    {max_frequency, stop_frequency} = {16'h1388, 16'h0320};
    {motor_rated_current, drive_rated_current} = {16'h00c8, 16'h00c8};
    launch_frequency = 16'h0064 + 16'($unsigned($random(seed)) % 800);
    target_frequency = 16'h0bb8;
    w(5);
    rst = 1'b0;
    go(0, 0, 2, 1, 0); w(4); ex(6'h20, 0, 16'h0050, 1);
    w(20); ex(6'h04, launch_frequency, 0, 3);
    w(14); ex(6'h02, 0, 0, 1); halt;
    go(0, 0, 0, 2, 0); ex(6'h04, launch_frequency, 0, 3);
    w(25); ex(6'h02, 0, 0, 1); halt;
    go(0, 0, 0, 3, 1); w(3); ex(6'h02, 0, 0, 1); halt;
    go(2, 0, 1, 1, 1); ex(6'h04, launch_frequency, 0, 3); halt;
    go(2, 1, 2, 0, 1); w(4); ex(6'h10, 0, 16'h0050, 1);
    w(25); ex(6'h02, 0, 0, 1); halt;
    go(2, 1, 0, 1, 1); ex(6'h04, launch_frequency, 0, 3); halt;
    target_frequency = launch_frequency - 16'h0001;
    go(0, 0, 0, 1, 1); w(3); ex(6'h01, 0, 0, 3);
    target_frequency = launch_frequency;
    w(3); ex(6'h04, launch_frequency, 0, 3); halt;
    {target_frequency, launch_frequency} = {16'h0bb8, 16'h07d0};
    go(0, 0, 0, 1, 1); ex(6'h04, 16'h03e8, 0, 3); halt;
    for (int o = 0; o < 3; o++) begin
      tracking_origin_select = o[1:0];
      tracking_rate = 7'($unsigned($random(seed)) % 100 + 1);
      org = (o == 0) ? 16'h0320 : (o == 1) ? 16'h0000 : 16'h1388;
      go(1, 0, 0, 0, 1); ex(6'h08, org, 0, 3);
      // Model locks after 20 cycles of search and reports 0x400 plus 20
      w(25); ex(6'h02, 16'h0414, 0, 3); halt;
    end
    go(0, 0, 5, 0, 1); w(12); halt; ex(6'h00, 0, 0, 3);
    w(2);
    stop_test;
  end
endmodule // mss_motor_start_sequencer_tb
